/* File: lfm_pkg.sv */
// Package with the constants shared by the fault and mask command logic.
package lfm_pkg;

  // Channel count and serial word width.
  localparam int unsigned LFM_CHANNELS = 16;
  localparam int unsigned LFM_WORD_W = 16;
  localparam int unsigned LFM_CNT_W = 4;

  // Shift-clock pulse counts that select each command.
  localparam logic [3:0] LFM_CNT_START_LO = 4'h2;
  localparam logic [3:0] LFM_CNT_START_HI = 4'h3;
  localparam logic [3:0] LFM_CNT_MASK_LO = 4'h7;
  localparam logic [3:0] LFM_CNT_MASK_HI = 4'h8;
  localparam logic [3:0] LFM_CNT_CHECK_LO = 4'h9;
  localparam logic [3:0] LFM_CNT_CHECK_HI = 4'hA;
  localparam logic [3:0] LFM_CNT_CLEAR_LO = 4'hB;
  localparam logic [3:0] LFM_CNT_CLEAR_HI = 4'hC;
  localparam logic [3:0] LFM_CNT_MAX = 4'hF;
  localparam logic [3:0] LFM_CNT_ONE = 4'h1;

  // Reset value of the enable mask: every channel follows its PWM data.
  localparam logic [15:0] LFM_MASK_RESET = 16'hFFFF;

  // Fault result codes and the reset value of the result word.
  localparam logic LFM_CODE_FAULT = 1'b0;
  localparam logic LFM_CODE_NORMAL = 1'b1;
  localparam logic [15:0] LFM_RESULT_RESET = 16'hFFFF;

  // Low-step limits at or below which automatic detection reports normal.
  localparam logic [15:0] LFM_NORMAL_LIMIT = 16'h0014;
  localparam logic [15:0] LFM_DIV_LIMIT_WIDE = 16'h0A00;
  localparam logic [15:0] LFM_DIV_LIMIT_NARROW = 16'h03C0;

  // Manual check window: time in ns and the clock period in ps.
  localparam int unsigned LFM_WINDOW_NS = 800;
  localparam int unsigned LFM_CLK_PS = 4000;
  localparam int unsigned LFM_WINDOW_CYC =
    (LFM_WINDOW_NS * 1000 + LFM_CLK_PS - 1) / LFM_CLK_PS;

  // PWM resolution codes as given on the resolution input.
  localparam logic [1:0] LFM_RES_16 = 2'h0;
  localparam logic [1:0] LFM_RES_14 = 2'h1;

  // Commands decoded from the pulse count.
  typedef enum logic [2:0] {
    LFM_CMD_NONE,
    LFM_CMD_START,
    LFM_CMD_MASK,
    LFM_CMD_CHECK,
    LFM_CMD_CLEAR
  } lfm_cmd_t;

  // States of the manual check sequencer.
  typedef enum logic [1:0] {
    LFM_ST_IDLE,
    LFM_ST_WAIT_END,
    LFM_ST_WINDOW
  } lfm_state_t;

endpackage

/* File: lfm_sync.sv */
// Two flip-flop synchroniser for levels entering the core clock domain.
`timescale 1ns/1ps
module lfm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta_q;

  // Both stages clear to zero under reset.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

/* File: lfm_cmd_core.sv */
// Serial command decoder for fault result, enable mask and counter clear.
`timescale 1ns/1ps
module lfm_cmd_core #(
  parameter int unsigned CHANNELS = lfm_pkg::LFM_CHANNELS,
  parameter int unsigned WINDOW_CYC = lfm_pkg::LFM_WINDOW_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_command_strobe,
  input wire logic i_serial_in,
  input wire logic i_fault_detect_en,
  input wire logic i_oneshot_mode,
  input wire logic i_async_mode,
  input wire logic i_division_mode,
  input wire logic [1:0] i_pwm_res,
  input wire logic i_pwm_running,
  input wire logic i_pwm_period_end,
  input wire logic i_auto_sample,
  input wire logic [lfm_pkg::LFM_WORD_W*CHANNELS-1:0] i_pwm_setting,
  input wire logic [CHANNELS-1:0] i_sense_fault,
  output logic o_serial_out,
  output logic o_pwm_start,
  output logic o_counter_clear,
  output logic o_force_sense_on,
  output logic [CHANNELS-1:0] o_channel_enable,
  output logic [CHANNELS-1:0] o_fault_result
);
  import lfm_pkg::*;

  // The word width fixes the channel count; other values are refused.
  if (CHANNELS != LFM_WORD_W) begin : g_bad_channels
    $error("CHANNELS must equal the serial word width");
  end
  if (WINDOW_CYC < 2 || WINDOW_CYC > 255) begin : g_bad_window
    $error("WINDOW_CYC must lie between 2 and 255");
  end

  localparam logic [7:0] WIN_LAST = 8'(WINDOW_CYC - 1);

  // Maps a pulse count to a command; counts in no pair give none.
  function automatic lfm_cmd_t cmd_of(input logic [3:0] cnt);
    lfm_cmd_t c;
    c = LFM_CMD_NONE;
    if (cnt == LFM_CNT_START_LO || cnt == LFM_CNT_START_HI) begin
      c = LFM_CMD_START;
    end else if (cnt == LFM_CNT_MASK_LO || cnt == LFM_CNT_MASK_HI) begin
      c = LFM_CMD_MASK;
    end else if (cnt == LFM_CNT_CHECK_LO || cnt == LFM_CNT_CHECK_HI) begin
      c = LFM_CMD_CHECK;
    end else if (cnt == LFM_CNT_CLEAR_LO || cnt == LFM_CNT_CLEAR_HI) begin
      c = LFM_CMD_CLEAR;
    end
    return c;
  endfunction

  // ---------------- Link side, clocked by the shift clock ----------------

  logic [LFM_WORD_W-1:0] shreg_q; // Serial shift register.
  logic [LFM_WORD_W-1:0] frame_word_q; // Word frozen at strobe rise.
  logic [LFM_CNT_W-1:0] pulse_cnt_q; // Edges seen with strobe high.
  logic strobe_seen_q; // Strobe level at the previous edge.
  logic unload_seen_q; // Last result toggle already unloaded.
  logic serial_out_q; // Serial output bit.
  logic [LFM_WORD_W-1:0] result_q; // Result word, core domain.
  logic unload_tog_q; // Toggles when a new result waits, core domain.
  logic frame_tog_q; // Toggles at each decoded frame end, core domain.
  logic frame_seen_q; // Last frame toggle already seen, link domain.

  // The result word and its toggle are held still for the whole check
  // window, during which the host keeps the shift clock low; the first
  // shift-clock edge after it therefore sees settled values.
  wire unload_now = (unload_tog_q != unload_seen_q) && !i_command_strobe;
  // A frame end since the last edge restarts the count, so two frames
  // with no data shifted between them are still counted apart.
  wire frame_new = (frame_tog_q != frame_seen_q);
  wire [LFM_CNT_W-1:0] pulse_cnt_d = (!strobe_seen_q || frame_new) ?
    LFM_CNT_ONE :
    (pulse_cnt_q == LFM_CNT_MAX) ? pulse_cnt_q : pulse_cnt_q + LFM_CNT_ONE;

  // Counts edges while the strobe is high; the word stays frozen then.
  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_cnt_q <= '0;
      strobe_seen_q <= 1'b0;
      frame_word_q <= '0;
      frame_seen_q <= 1'b0;
    end else begin
      strobe_seen_q <= i_command_strobe;
      if (i_command_strobe) begin
        pulse_cnt_q <= pulse_cnt_d;
        frame_word_q <= shreg_q;
        frame_seen_q <= frame_tog_q;
      end
    end
  end

  // Shifts MSB first; the first edge after a result ignores the input.
  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg_q <= '0;
      serial_out_q <= 1'b0;
      unload_seen_q <= 1'b0;
    end else if (unload_now) begin
      shreg_q <= {result_q[LFM_WORD_W-2:0], 1'b0};
      serial_out_q <= result_q[LFM_WORD_W-1];
      unload_seen_q <= unload_tog_q;
    end else if (!i_command_strobe) begin
      shreg_q <= {shreg_q[LFM_WORD_W-2:0], i_serial_in};
      serial_out_q <= shreg_q[LFM_WORD_W-1];
    end
  end

  assign o_serial_out = serial_out_q;

  // ---------------- Core side, clocked by i_clk ----------------

  logic strobe_sync; // Strobe after two flip-flops.
  logic strobe_old_q; // Strobe one core cycle earlier.

  lfm_sync #(
    .WIDTH(1)
  ) u_strobe_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_command_strobe),
    .o_sync(strobe_sync)
  );

  // The count and the frozen word are still while the strobe is low and
  // the shift clock idles, so the synced falling edge qualifies them.
  wire frame_end = strobe_old_q && !strobe_sync;
  wire lfm_cmd_t cmd = frame_end ? cmd_of(pulse_cnt_q) : LFM_CMD_NONE;
  wire do_start = (cmd == LFM_CMD_START);
  wire do_mask = (cmd == LFM_CMD_MASK);
  wire do_clear = (cmd == LFM_CMD_CLEAR);
  wire do_check = (cmd == LFM_CMD_CHECK) && i_fault_detect_en;

  lfm_state_t state_q, state_d; // Manual check sequencer.
  logic [7:0] win_cnt_q; // Cycles left in the check window.
  logic [CHANNELS-1:0] mask_pend_q; // Mask waiting to take effect.
  logic [CHANNELS-1:0] mask_live_q; // Mask that gates the channels.
  logic mask_wait_q; // A pending mask waits for the period end.
  logic blocked_q; // Channels held off after a counter clear.
  logic start_q; // Start pulse register.
  logic clear_q; // Counter clear pulse register.
  logic force_q; // Forced small-current window.
  logic [CHANNELS-1:0] en_q; // Channel enables to the output stage.

  // Low-step test per channel for automatic detection.
  wire res_wide = (i_pwm_res == LFM_RES_16) || (i_pwm_res == LFM_RES_14);
  wire [15:0] div_limit = res_wide ? LFM_DIV_LIMIT_WIDE : LFM_DIV_LIMIT_NARROW;
  logic [CHANNELS-1:0] auto_word; // Automatic result, low steps forced.

  for (genvar n = 0; n < CHANNELS; n++) begin : g_auto
    wire [15:0] step = i_pwm_setting[n*LFM_WORD_W +: LFM_WORD_W];
    wire low_normal = (step <= LFM_NORMAL_LIMIT);
    wire low_div = (step <= div_limit);
    wire low = i_division_mode ? low_div : low_normal;
    // Sense high means open or short, shown as the shared zero code.
    assign auto_word[n] = low ? LFM_CODE_NORMAL :
      (i_sense_fault[n] ? LFM_CODE_FAULT : LFM_CODE_NORMAL);
  end

  // Manual result: raw sense, no low-step forcing, bit n is channel n.
  wire [CHANNELS-1:0] manual_word = ~i_sense_fault;
  wire win_done = (state_q == LFM_ST_WINDOW) && (win_cnt_q == '0);

  // Sequencer: defer in one-shot mode while PWM runs, then the window.
  always_comb begin
    state_d = state_q;
    case (state_q)
      LFM_ST_IDLE: begin
        if (do_check) begin
          // In repeat mode the host clears first, so PWM is idle.
          if (i_oneshot_mode && i_pwm_running) begin
            state_d = LFM_ST_WAIT_END;
          end else begin
            state_d = LFM_ST_WINDOW;
          end
        end
      end
      LFM_ST_WAIT_END: begin
        if (i_pwm_period_end || !i_pwm_running) begin
          state_d = LFM_ST_WINDOW;
        end
      end
      LFM_ST_WINDOW: begin
        if (win_cnt_q == '0) begin
          state_d = LFM_ST_IDLE;
        end
      end
      default: begin
        state_d = LFM_ST_IDLE;
      end
    endcase
  end

  // Window counter and the forced-on window, aligned with the state.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= LFM_ST_IDLE;
      win_cnt_q <= '0;
      force_q <= 1'b0;
      strobe_old_q <= 1'b0;
      frame_tog_q <= 1'b0;
    end else begin
      state_q <= state_d;
      strobe_old_q <= strobe_sync;
      // Tells the link side that the next strobe opens a new count.
      if (frame_end) begin
        frame_tog_q <= !frame_tog_q;
      end
      force_q <= (state_d == LFM_ST_WINDOW);
      if (state_q != LFM_ST_WINDOW) begin
        win_cnt_q <= WIN_LAST;
      end else if (win_cnt_q != '0) begin
        win_cnt_q <= win_cnt_q - 8'h01;
      end
    end
  end

  // Result capture at the window end or on an automatic sample; the
  // toggle hands the word to the link side for the next shift edge.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_q <= LFM_RESULT_RESET;
      unload_tog_q <= 1'b0;
    end else if (win_done) begin
      result_q <= manual_word;
      unload_tog_q <= !unload_tog_q;
    end else if (i_auto_sample && i_fault_detect_en) begin
      result_q <= auto_word;
      unload_tog_q <= !unload_tog_q;
    end
  end

  // Mask timing: asynchronous mode or idle PWM applies at once,
  // synchronous mode waits for the end of the running period.
  wire apply_now = do_mask && (i_async_mode || !i_pwm_running);
  wire apply_late = mask_wait_q && (i_pwm_period_end || !i_pwm_running);
  wire [CHANNELS-1:0] mask_live_d = apply_now ? frame_word_q :
    (apply_late ? mask_pend_q : mask_live_q);
  wire blocked_d = do_clear ? 1'b1 : (do_start ? 1'b0 : blocked_q);

  // Mask registers; other commands leave them alone.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_pend_q <= LFM_MASK_RESET;
      mask_live_q <= LFM_MASK_RESET;
      mask_wait_q <= 1'b0;
    end else begin
      mask_live_q <= mask_live_d;
      if (do_mask) begin
        mask_pend_q <= frame_word_q;
        mask_wait_q <= !apply_now;
      end else if (apply_late) begin
        mask_wait_q <= 1'b0;
      end
    end
  end

  // Channel gating: a zero mask bit or a clear turns a channel off
  // without touching the stored PWM data.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blocked_q <= 1'b0;
      en_q <= LFM_MASK_RESET;
      start_q <= 1'b0;
      clear_q <= 1'b0;
    end else begin
      blocked_q <= blocked_d;
      en_q <= blocked_d ? '0 : mask_live_d;
      start_q <= do_start;
      clear_q <= do_clear;
    end
  end

  assign o_pwm_start = start_q;
  assign o_counter_clear = clear_q;
  assign o_force_sense_on = force_q;
  assign o_channel_enable = en_q;
  assign o_fault_result = result_q;

  // ---------------- Checks ----------------

  a_mask_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    do_mask |=> mask_pend_q == $past(frame_word_q))
    else $error("mask command did not store the word");

  a_check_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == LFM_ST_IDLE && frame_end && !i_fault_detect_en)
    |=> state_q == LFM_ST_IDLE)
    else $error("check ran with detection disabled");

  a_window_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(force_q) |-> ##199 force_q ##1 !force_q)
    else $error("check window has the wrong length");

  a_clear_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    do_clear |=> o_counter_clear && o_channel_enable == '0)
    else $error("clear did not pulse or turn channels off");

  a_blocked_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (blocked_q && !do_start) |=> o_channel_enable == '0)
    else $error("channel on before start after clear");

  a_async_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (do_mask && i_async_mode) |=> mask_live_q == $past(frame_word_q))
    else $error("asynchronous mask not applied at once");

  a_sync_defer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (do_mask && !i_async_mode && i_pwm_running && !mask_wait_q)
    |=> $stable(mask_live_q))
    else $error("synchronous mask applied mid period");

  a_oneshot_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (do_check && state_q == LFM_ST_IDLE && i_oneshot_mode && i_pwm_running)
    |=> !o_force_sense_on)
    else $error("one-shot check did not wait for period end");

  a_manual_raw: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    win_done |=> o_fault_result == ~$past(i_sense_fault))
    else $error("manual result not the raw sense word");

  a_start_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    do_start |=> o_pwm_start ##1 !o_pwm_start)
    else $error("start pulse wrong");

  c_mask_cmd: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    do_mask);
  c_check_done: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    win_done);
  c_clear_start: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    do_clear ##[1:1000] do_start);

endmodule

/* File: lfm_host_model.sv */
// Host model that drives the serial clock, strobe and data lines.
`timescale 1ns/1ps
module lfm_host_model (
  input wire logic i_serial_out,
  output logic o_sck,
  output logic o_command_strobe,
  output logic o_serial_in
);
  // Half period of the 48 ns link clock.
  localparam time HALF = 24;

  // All lines start low; the clock only runs while a task below shifts a word or sends a frame.
  initial begin
    o_sck = 1'b0;
    o_command_strobe = 1'b0;
    o_serial_in = 1'b0;
  end

  // One clock pulse, leaving the clock low afterwards.
  task automatic pulse();
    #HALF o_sck = 1'b1;
    #HALF o_sck = 1'b0;
  endtask

  // Shift a word in, top bit first; the data line then flips so a late
  // sample can never pass by luck.
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      o_serial_in = w[i];
      pulse();
    end
    o_serial_in = ~o_serial_in;
  endtask

  // Strobe high over n pulses, then a long quiet gap for decoding.
  task automatic frame(input int n);
    o_command_strobe = 1'b1;
    repeat (n) pulse();
    #HALF o_command_strobe = 1'b0;
    #(4 * HALF);
  endtask

  // Clock a result word out; the data line toggles on every pulse,
  // because the core must ignore it on the first one.
  task automatic read_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      o_serial_in = ~o_serial_in;
      #HALF o_sck = 1'b1;
      #(HALF - 1) w[i] = i_serial_out;
      #1 o_sck = 1'b0;
    end
  endtask
endmodule

/* File: lfm_cmd_core_tb.sv */
// Self-checking bench for the fault result and enable mask commands.
`timescale 1ns/1ps
module lfm_cmd_core_tb;
  import lfm_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b1;
  logic sck, strobe, serial_in, sout;
  logic det_en = 1'b0;
  logic oneshot = 1'b0;
  logic async_m = 1'b0;
  logic div_m = 1'b0;
  logic [1:0] res = 2'h0;
  logic running = 1'b0;
  logic period_end = 1'b0;
  logic auto_s = 1'b0;
  logic [255:0] setting = '0;
  logic [15:0] sense = 16'h0000;
  logic start_p, clear_p, force_on;
  logic [15:0] enable, result, word, lim;
  int fails = 0;
  int samples_checked = 0;
  int n_start = 0;
  int n_clear = 0;
  int n_force = 0;

  // Core clock at 250 MHz.
  always #2 i_clk = ~i_clk;

  lfm_cmd_core DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(sck),
    .i_command_strobe(strobe), .i_serial_in(serial_in),
    .i_fault_detect_en(det_en), .i_oneshot_mode(oneshot),
    .i_async_mode(async_m), .i_division_mode(div_m), .i_pwm_res(res),
    .i_pwm_running(running), .i_pwm_period_end(period_end),
    .i_auto_sample(auto_s), .i_pwm_setting(setting),
    .i_sense_fault(sense), .o_serial_out(sout), .o_pwm_start(start_p),
    .o_counter_clear(clear_p), .o_force_sense_on(force_on),
    .o_channel_enable(enable), .o_fault_result(result)
  );

  lfm_host_model host (
    .i_serial_out(sout), .o_sck(sck), .o_command_strobe(strobe),
    .o_serial_in(serial_in)
  );

  // Start and clear pulses are one cycle wide, so they are counted at every edge; the window line adds one per cycle it is high.
  always @(posedge i_clk) begin
    if (start_p === 1'b1) n_start <= n_start + 1;
    if (clear_p === 1'b1) n_clear <= n_clear + 1;
    if (force_on === 1'b1) n_force <= n_force + 1;
  end

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compares one 16-bit result.
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Waits a bounded time for the sense window line to reach v.
  task automatic wait_force(input logic v, input int lim_c);
    int k;
    k = 0;
    while (force_on !== v && k < lim_c) begin
      @(negedge i_clk);
      k++;
    end
    if (force_on !== v) begin
      fails++;
      close_out();
    end
  endtask

  // A data word then a command frame; back on a falling edge after.
  task automatic cmd(input logic [15:0] w, input int n);
    host.send_word(w);
    host.frame(n);
    @(negedge i_clk);
  endtask

  // One-cycle pulse on the period end input.
  task automatic end_period();
    period_end = 1'b1;
    @(negedge i_clk);
    period_end = 1'b0;
  endtask

  // Cuts a hang short.
  initial begin
    #300us;
    fails++;
    close_out();
  end

  initial begin
    // A real falling reset edge, because the shift-clock side sees no
    // clock edge before the first data word and must still clear.
    #1 i_rst_n = 1'b0;
    cycles(20);
    i_rst_n = 1'b1;
    cycles(4);
    chk("enable", LFM_MASK_RESET, enable);
    chk("result", LFM_RESULT_RESET, result);
    // Asynchronous mode: the mask lands even while a period runs.
    async_m = 1'b1;
    running = 1'b1;
    cmd(16'hA5C3, 7);
    chk("enable", 16'hA5C3, enable);
    cmd(16'h3C0F, 8);
    chk("enable", 16'h3C0F, enable);
    cmd(16'h0000, 5);
    chk("enable", 16'h3C0F, enable);
    // Synchronous mode: the mask waits for the period to end.
    async_m = 1'b0;
    cmd(16'h00FF, 7);
    chk("enable", 16'h3C0F, enable);
    end_period();
    cycles(2);
    chk("enable", 16'h00FF, enable);
    running = 1'b0;
    // Both counts of clear and start; the start frame follows with no
    // data between, so the count must restart at each strobe.
    for (int i = 0; i < 2; i++) begin
      cmd(16'h0000, 11 + i);
      chk("enable", 16'h0000, enable);
      host.frame(2 + i);
      @(negedge i_clk);
      chk("enable", 16'h00FF, enable);
    end
    chk("clears", 16'h0002, 16'(n_clear));
    chk("starts", 16'h0002, 16'(n_start));
    // With detection disabled the check must not run.
    cmd(16'h0000, 9);
    cycles(60);
    chk("window", 16'h0000, 16'(n_force));
    // Repeat mode: clear first, then a manual check.
    det_en = 1'b1;
    sense = 16'h8001;
    cmd(16'h0000, 11);
    cmd(16'h0000, 9);
    wait_force(1'b1, 50);
    wait_force(1'b0, 300);
    chk("window", 16'(LFM_WINDOW_CYC), 16'(n_force));
    chk("result", 16'h7FFE, result);
    host.read_word(word);
    chk("shifted", 16'h7FFE, word);
    // One-shot mode while running: the check waits for the period end.
    @(negedge i_clk);
    oneshot = 1'b1;
    running = 1'b1;
    sense = 16'hFFFF;
    cmd(16'h0000, 10);
    cycles(60);
    chk("window", 16'(LFM_WINDOW_CYC), 16'(n_force));
    end_period();
    wait_force(1'b1, 10);
    wait_force(1'b0, 300);
    running = 1'b0;
    chk("result", 16'h0000, result);
    // Automatic capture in normal mode and at every resolution code of
    // division mode: channel 0 sits at the limit, the rest above it.
    for (int i = 0; i < 5; i++) begin
      div_m = (i != 0);
      res = (i == 0) ? LFM_RES_16 : 2'(i - 1);
      lim = (i == 0) ? LFM_NORMAL_LIMIT :
            (i < 3) ? LFM_DIV_LIMIT_WIDE : LFM_DIV_LIMIT_NARROW;
      for (int c = 0; c < 16; c++) setting[16*c +: 16] = lim + 16'h0001;
      setting[15:0] = lim;
      auto_s = 1'b1;
      @(negedge i_clk);
      auto_s = 1'b0;
      cycles(3);
      chk("auto result", 16'h0001, result);
    end
    close_out();
  end
endmodule
